/* File: hw/lss_top.sv */
`timescale 1ns/1ps
// Operation
// - blank high forces all sixteen channel outputs off regardless of on/off bits
// - blank low lets each channel follow its on/off bit and correction value
// - sixteen on/off bits are held and updated together from one packet
// - channel fields arrive back to back, msb first, no separators
// - mode low: shift register is 16 bits, latch targets on/off register
// - latch edge loads on/off register; only honoured while blank is high
// - turn-on staggered: channel n starts n steps of 20 ns after channel 0
// - each shift clock rising edge shifts serial input into the shift register, unless the event queue is full (edge dropped, overflow set)
// - latch rising edge copies shift register into register chosen by mode
// - serial output carries shift data so devices can be chained
// - mode high: shift register is 112 bits for correction data
// - correction packet is sixteen 7-bit words, msb first, 112 bits
// - in correction mode, latch edge loads the correction register
// - channel current scales with its 7-bit value, 0 off, 127 full
module lss_top #(
  parameter int NUM_CH = lss_pkg::NUM_CH,
  parameter int FIFO_DEPTH = lss_pkg::FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic shift_clk,
  input wire logic serial_in,
  input wire logic latch_strobe,
  input wire logic mode,
  input wire logic blank,
  input wire logic overflow_clr,
  output logic serial_out,
  output logic [NUM_CH-1:0] chan_drive,
  output logic [NUM_CH-1:0] chan_on,
  output logic [lss_pkg::DC_LEN-1:0] dot_correction_value,
  output logic accept_ready,
  output logic overflow
);
  localparam int DC_W = lss_pkg::DC_W;
  localparam int DC_LEN = lss_pkg::DC_LEN;
  localparam int ONOFF_LEN = lss_pkg::ONOFF_LEN;
  localparam int SW = lss_pkg::STAGGER_W;
  localparam logic [SW-1:0] STAG_LAST = SW'(lss_pkg::STAGGER_LAST);

  // pin edge detection
  logic sclk_prev;
  logic latch_strobe_prev;
  logic latch_pend;
  logic pend_mode;
  logic pend_blank;
  logic next_sclk_prev;
  logic next_latch_strobe_prev;
  logic next_latch_pend;
  logic next_pend_mode;
  logic next_pend_blank;
  logic sclk_rise;
  logic latch_strobe_rise;

  // event queue
  lss_pkg::lss_evt_s push_evt;
  lss_pkg::lss_evt_s head_evt;
  logic push_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic pop;

  // shift and holding registers
  lss_pkg::lss_drain_e state;
  lss_pkg::lss_drain_e next_state;
  logic [DC_LEN-1:0] sr;
  logic [DC_LEN-1:0] next_sr;
  logic [DC_LEN-1:0] next_dc;
  logic [NUM_CH-1:0] next_onoff;
  logic next_serial_out;

  // output stage
  logic [SW-1:0] stag_cnt;
  logic [SW-1:0] next_stag_cnt;
  logic [DC_W-1:0] pwm_cnt;
  logic [DC_W-1:0] next_pwm_cnt;
  logic [NUM_CH-1:0] next_drive;
  logic next_overflow;
  logic ramp_busy;

  function automatic logic rose(input logic cur, input logic prev);
    rose = cur && !prev;
  endfunction

  function automatic logic [SW-1:0] stag_thresh(input int ch);
    stag_thresh = SW'(ch * lss_pkg::STAGGER_STEP_CYC);
  endfunction

  function automatic logic [DC_W-1:0] dc_of(input logic [DC_LEN-1:0] v, input int ch);
    dc_of = v[ch*DC_W +: DC_W];
  endfunction

  // ---- pin sampling and event generation
  always_comb
  begin
    sclk_rise = rose(shift_clk, sclk_prev);
    latch_strobe_rise = rose(latch_strobe, latch_strobe_prev);
    next_sclk_prev = shift_clk;
    next_latch_strobe_prev = latch_strobe;
    next_latch_pend = latch_pend;
    next_pend_mode = pend_mode;
    next_pend_blank = pend_blank;
    push_evt = '0;
    push_valid = 1'b0;
    if (sclk_rise)
    begin
      // shift event wins the slot, latch waits behind it
      push_valid = 1'b1;
      push_evt.is_latch = 1'b0;
      push_evt.mode = mode;
      push_evt.blank = blank;
      push_evt.data = serial_in;
    end
    else if (latch_pend)
    begin
      push_valid = 1'b1;
      push_evt.is_latch = 1'b1;
      push_evt.mode = pend_mode;
      push_evt.blank = pend_blank;
      if (fifo_in_ready)
      begin
        next_latch_pend = 1'b0;
      end
    end
    if (latch_strobe_rise)
    begin
      next_latch_pend = 1'b1;
      next_pend_mode = mode;
      next_pend_blank = blank;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      sclk_prev <= 1'b0;
      latch_strobe_prev <= 1'b0;
      latch_pend <= 1'b0;
      pend_mode <= 1'b0;
      pend_blank <= 1'b0;
    end
    else
    begin
      sclk_prev <= next_sclk_prev;
      latch_strobe_prev <= next_latch_strobe_prev;
      latch_pend <= next_latch_pend;
      pend_mode <= next_pend_mode;
      pend_blank <= next_pend_blank;
    end
  end

  lss_fifo #(
    .WIDTH(lss_pkg::EVT_W),
    .DEPTH(FIFO_DEPTH)
  ) u_evt_fifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_valid(push_valid),
    .in_ready(fifo_in_ready),
    .in_data(push_evt),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(head_evt)
  );

  // ---- drain: shift register and holding registers
  always_comb
  begin
    next_state = state;
    next_sr = sr;
    next_serial_out = serial_out;
    next_onoff = chan_on;
    next_dc = dot_correction_value;
    pop = 1'b0;
    case (state)
      lss_pkg::DR_RUN:
      begin
        if (fifo_out_valid && !head_evt.is_latch)
        begin
          pop = 1'b1;
          if (head_evt.mode)
          begin
            next_serial_out = sr[DC_LEN-1];
            next_sr = {sr[DC_LEN-2:0], head_evt.data};
          end
          else
          begin
            next_serial_out = sr[ONOFF_LEN-1];
            next_sr[ONOFF_LEN-1:0] = {sr[ONOFF_LEN-2:0], head_evt.data};
          end
        end
        else if (fifo_out_valid && head_evt.mode)
        begin
          // correction update held until the turn-on ramp settles
          if (ramp_busy)
          begin
            next_state = lss_pkg::DR_WAIT_RAMP;
          end
          else
          begin
            pop = 1'b1;
            next_dc = sr;
          end
        end
        else if (fifo_out_valid)
        begin
          pop = 1'b1;
          if (head_evt.blank)
          begin
            next_onoff = sr[ONOFF_LEN-1:0];
          end
        end
      end
      lss_pkg::DR_WAIT_RAMP:
      begin
        if (!ramp_busy)
        begin
          pop = 1'b1;
          next_dc = sr;
          next_state = lss_pkg::DR_RUN;
        end
      end
      default:
      begin
        next_state = lss_pkg::DR_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state <= lss_pkg::DR_RUN;
      sr <= lss_pkg::SR_RST;
      serial_out <= 1'b0;
      chan_on <= lss_pkg::ONOFF_RST;
      dot_correction_value <= lss_pkg::DC_RST;
    end
    else
    begin
      state <= next_state;
      sr <= next_sr;
      serial_out <= next_serial_out;
      chan_on <= next_onoff;
      dot_correction_value <= next_dc;
    end
  end

  // ---- channel drive: blanking, stagger and current duty
  always_comb
  begin
    ramp_busy = !blank && (stag_cnt != STAG_LAST);
    next_stag_cnt = stag_cnt;
    if (blank)
    begin
      next_stag_cnt = '0;
    end
    else if (stag_cnt != STAG_LAST)
    begin
      next_stag_cnt = SW'(stag_cnt + 1'b1);
    end
    // duty period of 127 cycles so full scale never switches off
    next_pwm_cnt = (pwm_cnt == lss_pkg::PWM_WRAP) ? '0 : DC_W'(pwm_cnt + 1'b1);
    for (int ch = 0; ch < NUM_CH; ch++)
    begin
      next_drive[ch] = !blank
        && chan_on[ch]
        && (stag_cnt >= stag_thresh(ch))
        && (pwm_cnt < dc_of(dot_correction_value, ch));
    end
    next_overflow = overflow;
    if (overflow_clr)
    begin
      next_overflow = 1'b0;
    end
    if (sclk_rise && !fifo_in_ready)
    begin
      next_overflow = 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      stag_cnt <= '0;
      pwm_cnt <= '0;
      chan_drive <= '0;
      accept_ready <= 1'b0;
      overflow <= 1'b0;
    end
    else
    begin
      stag_cnt <= next_stag_cnt;
      pwm_cnt <= next_pwm_cnt;
      chan_drive <= next_drive;
      accept_ready <= fifo_in_ready;
      overflow <= next_overflow;
    end
  end
endmodule

/* File: inc/lss_pkg.sv */
package lss_pkg;
  localparam int NUM_CH = 16;
  localparam int DC_W = 7;
  localparam int ONOFF_LEN = 16;
  localparam int DC_LEN = NUM_CH * DC_W;
  localparam int FIFO_DEPTH = 16;
  localparam int CLK_PERIOD_NS = 10;
  localparam int STAGGER_STEP_NS = 20;
  // typical step, rounded up to whole cycles, never below one
  localparam int STAGGER_STEP_RAW = (STAGGER_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STAGGER_STEP_CYC = (STAGGER_STEP_RAW < 1) ? 1 : STAGGER_STEP_RAW;
  localparam int STAGGER_LAST = (NUM_CH - 1) * STAGGER_STEP_CYC;
  localparam int STAGGER_W = $clog2(STAGGER_LAST + 1);
  localparam logic [DC_W-1:0] DC_FULL_SCALE = 7'h7f;
  localparam logic [DC_W-1:0] PWM_WRAP = 7'h7e;
  localparam logic [ONOFF_LEN-1:0] ONOFF_RST = 16'h0000;
  localparam logic [DC_LEN-1:0] DC_RST = 112'h0;
  localparam logic [DC_LEN-1:0] SR_RST = 112'h0;

  typedef struct packed {
    logic is_latch;
    logic mode;
    logic blank;
    logic data;
  } lss_evt_s;

  localparam int EVT_W = $bits(lss_evt_s);

  typedef enum {
    DR_RUN,
    DR_WAIT_RAMP
  } lss_drain_e;
endpackage

/* File: hw/lss_fifo.sv */
`timescale 1ns/1ps
module lss_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic [AW-1:0] next_wr_ptr;
  logic [AW-1:0] next_rd_ptr;
  logic [CW-1:0] next_count;
  logic do_wr;
  logic do_rd;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == LAST_IDX) ? '0 : AW'(p + 1'b1);
  endfunction

  assign in_ready = (count != FULL_CNT);
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  always_comb
  begin
    do_wr = in_valid && in_ready;
    do_rd = out_valid && out_ready;
    next_wr_ptr = do_wr ? bump(wr_ptr) : wr_ptr;
    next_rd_ptr = do_rd ? bump(rd_ptr) : rd_ptr;
    next_count = count;
    if (do_wr && !do_rd)
    begin
      next_count = CW'(count + 1'b1);
    end
    else if (do_rd && !do_wr)
    begin
      next_count = CW'(count - 1'b1);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (do_wr)
    begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

/* File: verification/lss_ctl_model.sv */
`timescale 1ns/1ps
// controller side: serial data, shift clock and latch only
module lss_ctl_model (
  input wire logic mclk,
  output logic shift_clk,
  output logic serial_in,
  output logic latch_strobe
);
  initial
  begin
    shift_clk = 1'b0;
    serial_in = 1'b0;
    latch_strobe = 1'b0;
  end
  // msb first, top channel first; bit rate far above the refresh need
  task automatic send(input int len, input logic [111:0] d);
    for (int i = len - 1; i >= 0; i--)
    begin
      @(posedge mclk);
      serial_in <= d[i];
      shift_clk <= 1'b1;
      @(posedge mclk);
      shift_clk <= 1'b0;
      serial_in <= ~d[i];
    end
  endtask
  task automatic pulse();
    @(posedge mclk);
    latch_strobe <= 1'b1;
    @(posedge mclk);
    latch_strobe <= 1'b0;
  endtask
endmodule

/* File: verification/lss_top_properties.sv */
`timescale 1ns/1ps
module lss_top_properties #(
  parameter int NUM_CH = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic shift_clk,
  input wire logic latch_strobe,
  input wire logic mode,
  input wire logic blank,
  input wire logic serial_out,
  input wire logic [NUM_CH-1:0] chan_drive,
  input wire logic [NUM_CH-1:0] chan_on,
  input wire logic [lss_pkg::DC_LEN-1:0] dot_correction_value
);
  logic prev_lat, prev_sh, lat_blank, lat_mode;
  logic [5:0] since_lat, since_sh;
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      prev_lat <= 1'b0;
      prev_sh <= 1'b0;
      lat_blank <= 1'b0;
      lat_mode <= 1'b0;
      since_lat <= 6'h3f;
      since_sh <= 6'h3f;
    end
    else
    begin
      prev_lat <= latch_strobe;
      prev_sh <= shift_clk;
      lat_blank <= (latch_strobe && !prev_lat) ? blank : lat_blank;
      lat_mode <= (latch_strobe && !prev_lat) ? mode : lat_mode;
      since_lat <= (latch_strobe && !prev_lat) ? 6'h0 : since_lat + 6'(since_lat != 6'h3f);
      since_sh <= (shift_clk && !prev_sh) ? 6'h0 : since_sh + 6'(since_sh != 6'h3f);
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_blank_off: assert property ($past(blank) |-> chan_drive == '0)
    else $error("outputs driven while blanked");
  a_drive_on: assert property ((chan_drive & ~$past(chan_on)) == '0)
    else $error("channel driven without its on bit");
  a_onoff_gate: assert property ($changed(chan_on) |-> lat_blank && since_lat <= 8)
    else $error("on/off register loaded without a blanked latch");
  a_onoff_mode: assert property ($changed(chan_on) |-> !lat_mode)
    else $error("on/off register loaded in correction mode");
  a_dc_mode: assert property ($changed(dot_correction_value) |-> lat_mode && since_lat <= 40)
    else $error("correction register loaded out of turn");
  a_serial_out_shift: assert property ($changed(serial_out) |-> since_sh <= 20)
    else $error("serial output moved without a shift");
  a_drive_dc: assert property (chan_drive[NUM_CH-1] |->
    $past(dot_correction_value[lss_pkg::DC_LEN-1 -: lss_pkg::DC_W]) != 7'h0)
    else $error("channel driven with zero correction");
  a_stagger_top: assert property ($fell(blank) |-> !chan_drive[NUM_CH-1] [*8])
    else $error("top channel turned on without stagger");
endmodule

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic mode = 1'b0;
  logic blank = 1'b1;
  logic overflow_clr = 1'b0;
  logic shift_clk, serial_in, latch_strobe, serial_out, accept_ready, overflow;
  logic [15:0] chan_drive, chan_on;
  logic [111:0] dot_correction_value;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  logic row_mode [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
  logic [111:0] row_data [4] = '{{7'h40, {14{7'h7f}}, 7'h01}, {16{7'h7f}}, 112'h8001, 112'hdaa5};
  always #5 mclk = ~mclk;
  lss_ctl_model u_ctl (.mclk(mclk), .shift_clk(shift_clk), .serial_in(serial_in),
    .latch_strobe(latch_strobe));
  lss_top u_dut (.mclk(mclk), .rst_n(rst_n), .shift_clk(shift_clk), .serial_in(serial_in),
    .latch_strobe(latch_strobe), .mode(mode), .blank(blank), .overflow_clr(overflow_clr),
    .serial_out(serial_out), .chan_drive(chan_drive), .chan_on(chan_on),
    .dot_correction_value(dot_correction_value), .accept_ready(accept_ready),
    .overflow(overflow));
  task automatic chk(input string what, input logic [111:0] exp, input logic [111:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      stop_test();
    end
  end
  initial
  begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    wait_cyc(3);
    chk("chan_on", 112'h0, chan_on);
    chk("accept_ready", 112'h1, accept_ready);
    $display("reset test done");
    for (int i = 0; i < 4; i++)
    begin
      @(posedge mclk) mode <= row_mode[i];
      u_ctl.send(row_mode[i] ? 112 : 16, row_data[i]);
      u_ctl.pulse();
      wait_cyc(8);
      if (row_mode[i])
        chk("dc", row_data[i], dot_correction_value);
      else
        chk("chan_on", row_data[i], chan_on);
      $display("row %0d done", i);
    end
    chk("dc", {16{7'h7f}}, dot_correction_value);
    @(posedge mclk) blank <= 1'b0;
    wait_cyc(40);
    chk("chan_drive", 112'hdaa5, chan_drive);
    u_ctl.send(16, 112'h7fff);
    u_ctl.pulse();
    wait_cyc(8);
    chk("chan_on", 112'hdaa5, chan_on);
    u_ctl.send(1, 112'h0);
    wait_cyc(3);
    chk("serial_out", 112'h0, serial_out);
    u_ctl.send(1, 112'h0);
    wait_cyc(3);
    chk("serial_out", 112'h1, serial_out);
    $display("chain test done");
    @(posedge mclk) blank <= 1'b1;
    wait_cyc(2);
    chk("chan_drive", 112'h0, chan_drive);
    @(posedge mclk) blank <= 1'b0;
    mode <= 1'b1;
    u_ctl.pulse();
    fork
      u_ctl.send(20, 112'h0);
      begin
        // correction update still held back by the turn-on ramp
        wait_cyc(20);
        chk("dc", {16{7'h7f}}, dot_correction_value);
      end
    join
    wait_cyc(40);
    chk("dc", {{27{4'hf}}, 4'hc}, dot_correction_value);
    chk("overflow", 112'h0, overflow);
    chk("accept_ready", 112'h1, accept_ready);
    @(posedge mclk) overflow_clr <= 1'b1;
    @(posedge mclk) overflow_clr <= 1'b0;
    wait_cyc(2);
    chk("overflow", 112'h0, overflow);
    $display("queue test done");
    @(posedge mclk) rst_n <= 1'b0;
    wait_cyc(3);
    chk("chan_on", 112'h0, chan_on);
    chk("dc", 112'h0, dot_correction_value);
    chk("serial_out", 112'h0, serial_out);
    @(posedge mclk) rst_n <= 1'b1;
    wait_cyc(3);
    chk("accept_ready", 112'h1, accept_ready);
    $display("second reset test done");
    stop_test();
  end
endmodule
bind lss_top lss_top_properties #(.NUM_CH(NUM_CH)) u_props (.mclk(mclk), .rst_n(rst_n),
  .shift_clk(shift_clk), .latch_strobe(latch_strobe), .mode(mode), .blank(blank),
  .serial_out(serial_out), .chan_drive(chan_drive), .chan_on(chan_on),
  .dot_correction_value(dot_correction_value));
